/* bench/tec_src_model.sv */
module tec_src_model (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [7:0] lat_i,
  input wire busy_i,
  input wire shut_i,
  output reg done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] cnt_reg;
  // sensor read-out ends lat_i + 1 cycles after the shutter closes
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h0;
      done_o <= 1'b0;
    end else if (busy_i && !shut_i && !done_o) begin
      done_o <= cnt_reg == lat_i;
      cnt_reg <= cnt_reg + 8'h1;
    end else begin
      done_o <= 1'b0;
      cnt_reg <= 8'h0;
    end
  end
endmodule // tec_src_model

/* bench/tec_trig_assertions.sv */
`include "tec_trigger_exposure_map.vh"
module tec_chk (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire shutter_open_o,
  input wire frame_start_o,
  input wire capture_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] meth_reg;
  reg [1:0] win_reg;
  reg [1:0] auto_reg;
  reg [15:0] wait_reg;
  reg [15:0] shut_reg;
  reg [23:0] cnt_reg;
  reg rsh_reg;
  reg rwt_reg;
  wire [7:0] a = reg_addr_i;
  wire sh = a == 8'h18 || a == 8'h1c || a == 8'h20;
  wire wt = a == 8'h04 || a == 8'h08 || a == 8'h0c;
  wire fix = meth_reg == `TEC_METHOD_FIXED;
  default clocking
    @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meth_reg <= 2'h0;
      win_reg <= 2'h0;
      auto_reg <= 2'h0;
      wait_reg <= `TEC_WAIT_RST;
      shut_reg <= `TEC_SHUT_RST;
      cnt_reg <= 24'h0;
      rsh_reg <= 1'b0;
      rwt_reg <= 1'b0;
    end else begin
      if (reg_wr_i && a == `TEC_ADDR_CTRL) begin
        meth_reg <= reg_wdata_i[`TEC_F_METHOD];
        win_reg <= reg_wdata_i[`TEC_F_WINDOW];
        auto_reg <= reg_wdata_i[`TEC_F_AUTO];
      end
      if (reg_wr_i && wt)
        wait_reg <= reg_wdata_i[15:0];
      if (reg_wr_i && sh)
        shut_reg <= reg_wdata_i[15:0];
      rsh_reg <= reg_rd_i && sh;
      rwt_reg <= reg_rd_i && wt;
      // exposure length counted from the frame start, fixed method only
      if (!fix)
        cnt_reg <= 24'h0;
      else if (frame_start_o)
        cnt_reg <= 24'h1;
      else if (cnt_reg != 24'h0)
        cnt_reg <= cnt_reg + 24'h1;
    end
  end
  a_off_open:
    assert property (meth_reg == 2'h0 && $past(meth_reg) == 2'h0
      |-> shutter_open_o) else $error("shutter shut in off method");
  a_fixed_start:
    assert property (fix && frame_start_o |-> shutter_open_o
      && capture_busy_o) else $error("fixed frame did not open");
  a_fixed_len:
    assert property (fix && auto_reg == 2'h0 && cnt_reg != 24'h0
      && $fell(shutter_open_o) |-> cnt_reg == shut_reg * `TEC_CYC_PER_US)
    else $error("fixed exposure length wrong");
  a_start_idle:
    assert property (win_reg == 2'h0 && frame_start_o
      |-> !$past(capture_busy_o)) else $error("start while busy");
  a_dedi_noframe:
    assert property (meth_reg == 2'h3 && $past(meth_reg) == 2'h3
      |-> !frame_start_o) else $error("frame in dedicated method");
  a_shut_mirror:
    assert property (rsh_reg && auto_reg == 2'h0
      |-> reg_rdata_o == {16'h0, $past(shut_reg)})
    else $error("shutter time forms differ");
  a_wait_mirror:
    assert property (rwt_reg |-> reg_rdata_o == {16'h0, $past(wait_reg)})
    else $error("wait forms differ");
  a_start_gap:
    assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start too long");
  c_fixed: cover property (fix && frame_start_o);
  c_close: cover property ($fell(shutter_open_o));
  c_dedi: cover property (meth_reg == 2'h3 && $rose(shutter_open_o));
endmodule // tec_chk

bind tec_trigger_exposure tec_chk u_tec_chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .shutter_open_o(shutter_open_o),
  .frame_start_o(frame_start_o),
  .capture_busy_o(capture_busy_o)
);

/* bench/testbench.sv */
`include "tec_trigger_exposure_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h0;
  logic [31:0] wd = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic fsrc = 1'b0;
  logic osrc = 1'b0;
  logic csrc = 1'b0;
  logic bright = 1'b0;
  logic dark = 1'b0;
  logic [7:0] lat = 8'h4;
  wire [31:0] rdat;
  wire shut;
  wire fst;
  wire busy;
  wire done;
  int bad_count = 0;
  int checked = 0;
  int starts = 0;
  int wid = 0;
  logic [31:0] v;
  logic [31:0] r;
  int ra[6] = '{0, 4, 16, 20, 24, 48};
  int rv[6] = '{0, 0, 1, 1, 1000, 0};
  int ke[5] = '{1, 1, 2, 1, 1};
  int ww[5] = '{0, 1, 2, 1, 0};
  int wg[5] = '{40, 40, 40, 150, 150};
  int wl[5] = '{4, 4, 4, 200, 200};
  int we[5] = '{1, 1, 2, 2, 1};
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (fst === 1'b1)
      starts++;
    if (shut === 1'b1)
      wid++;
  end
  tec_trigger_exposure u_tec_trigger_exposure (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .reg_addr_i(adr),
    .reg_wdata_i(wd),
    .reg_wr_i(wr_s),
    .reg_rd_i(rd_s),
    .reg_rdata_o(rdat),
    .frame_src_i(fsrc),
    .open_src_i(osrc),
    .close_src_i(csrc),
    .hold_src_i(1'b0),
    .after_exposure_accept_done_i(done),
    .scene_bright_i(bright),
    .scene_dark_i(dark),
    .shutter_open_o(shut),
    .frame_start_o(fst),
    .capture_busy_o(busy)
  );
  tec_src_model u_tec_src_model (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .lat_i(lat),
    .busy_i(busy),
    .shut_i(shut),
    .done_o(done)
  );
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk_i);
    wr_s <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge ref_clk_i);
    wr_s <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk_i);
    rd_s <= 1'b1;
    adr <= a;
    @(posedge ref_clk_i);
    rd_s <= 1'b0;
    #1 r = rdat;
  endtask
  task automatic src(logic b, int n);
    fsrc <= b;
    repeat (n) @(posedge ref_clk_i);
  endtask
  function automatic logic [31:0] mk(int k, int w, int m);
    mk = 32'((m << 18) | (w << 4) | (k << 1) | 1);
  endfunction
  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #600000;
    bad_count++;
    wrap_up;
  end
  initial begin
    int n;
    int m;
    int d;
    void'($urandom(32'h6f3d));
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1 chk("open", 1, shut);
    foreach (ra[i]) begin
      rd(8'(ra[i]));
      chk("reset", rv[i], r);
    end
    for (int i = 0; i < 6; i++) begin
      v = $urandom & 32'hffff;
      wr(8'(4 + 4 * (i % 3) + 20 * (i / 3)), v);
      rd(8'(4 + 4 * ((i + 1) % 3) + 20 * (i / 3)));
      chk("mirror", v, r);
    end
    $display("test registers finished");
    wr(8'h04, 0);
    wr(8'h18, 1);
    foreach (ke[k]) begin
      wr(`TEC_ADDR_CTRL, mk(k, 0, 1));
      starts = 0;
      src(1'b1, 600);
      src(1'b0, 600);
      chk("kind", ke[k], k > 2 ? 32'(starts > 2) : starts);
    end
    wr(`TEC_ADDR_CTRL, mk(0, 0, 1) - 1);
    starts = 0;
    src(1'b1, 300);
    src(1'b0, 300);
    chk("disabled", 0, starts);
    $display("test kinds finished");
    wr(8'h0c, 3);
    wr(`TEC_ADDR_CTRL, mk(0, 0, 1));
    src(1'b1, 0);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
    end while (fst !== 1'b1 && n < 999);
    chk("delay", 4 + 3 * `TEC_CYC_PER_US, n);
    @(posedge ref_clk_i);
    src(1'b0, 400);
    wr(8'h04, 0);
    repeat (3) begin
      d = 1 + $urandom % 3;
      m = 1 + $urandom % 3;
      wr(8'h10, d);
      wr(8'h14, m);
      starts = 0;
      repeat (2 * d) begin
        src(1'b1, 200);
        src(1'b0, 400);
      end
      chk("ratio", 2 * m, starts);
    end
    wr(8'h10, 1);
    wr(8'h14, 1);
    $display("test delay and ratio finished");
    foreach (ww[i]) begin
      lat <= 8'(wl[i]);
      wr(`TEC_ADDR_CTRL, mk(0, ww[i], 1));
      starts = 0;
      src(1'b1, 20);
      src(1'b0, wg[i]);
      src(1'b1, 20);
      src(1'b0, 800);
      chk("window", we[i], starts);
    end
    lat <= 8'h4;
    wr(`TEC_ADDR_CTRL, mk(0, 0, 2));
    wid = 0;
    src(1'b1, 150);
    src(1'b0, 300);
    chk("width", 149, wid);
    $display("test windows finished");
    dark <= 1'b1;
    wr(8'h18, 1);
    wr(`TEC_ADDR_CTRL, mk(0, 0, 1) | 32'h200000);
    src(1'b1, 100);
    src(1'b0, 300);
    rd(8'h18);
    chk("auto up", 1 + `TEC_AUTO_STEP_US, r);
    @(posedge ref_clk_i);
    dark <= 1'b0;
    wr(`TEC_ADDR_CTRL, mk(0, 0, 1) | 32'h100000);
    src(1'b1, 100);
    src(1'b0, 2000);
    rd(`TEC_ADDR_CTRL);
    chk("auto once", 0, r[21:20]);
    $display("test auto finished");
    wr(`TEC_ADDR_CTRL, 32'h0c00c1);
    starts = 0;
    osrc <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 chk("opened", 1, shut);
    @(posedge ref_clk_i);
    osrc <= 1'b0;
    csrc <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 chk("closed", 0, shut);
    @(posedge ref_clk_i);
    csrc <= 1'b0;
    src(1'b1, 50);
    src(1'b0, 50);
    chk("noframe", 0, starts);
    wr(`TEC_ADDR_CTRL, 32'h0400c0);
    osrc <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 chk("ignored", 0, shut);
    @(posedge ref_clk_i);
    osrc <= 1'b0;
    $display("test shutter triggers finished");
    wrap_up;
  end
endmodule // testbench

/* hdl/tec_trigger_exposure.v */
// The register addresses and strobed register access are this design's own decisions.
`include "tec_trigger_exposure_map.vh"

module tec_trigger_exposure (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  input wire frame_src_i,
  input wire open_src_i,
  input wire close_src_i,
  input wire hold_src_i,
  input wire after_exposure_accept_done_i,
  input wire scene_bright_i,
  input wire scene_dark_i,
  output reg shutter_open_o,
  output reg frame_start_o,
  output wire capture_busy_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXPOSE = 2'b10;

  function tec_qualify;
    input [2:0] kind;
    input cur;
    input prv;
    begin
      case (kind)
        `TEC_RISE_TRANSITION: tec_qualify = cur & ~prv;
        `TEC_FALL_TRANSITION: tec_qualify = ~cur & prv;
        `TEC_EITHER_TRANSITION: tec_qualify = cur ^ prv;
        `TEC_WHILE_HIGH: tec_qualify = cur;
        `TEC_WHILE_LOW: tec_qualify = ~cur;
        default: tec_qualify = 1'b0;
      endcase
    end
  endfunction

  // active level of a source for width-driven shutter control
  function tec_active;
    input [2:0] kind;
    input cur;
    begin
      if (kind == `TEC_FALL_TRANSITION || kind == `TEC_WHILE_LOW) begin
        tec_active = ~cur;
      end else begin
        tec_active = cur;
      end
    end
  endfunction

  function [23:0] tec_us_cyc;
    input [15:0] us;
    reg [31:0] prod;
    begin
      prod = {16'h0000, us} * `TEC_CYC_PER_US;
      tec_us_cyc = prod[23:0];
    end
  endfunction

  reg [`TEC_CTRL_W-1:0] ctrl_reg;
  reg [15:0] wait_us_reg;
  reg [15:0] div_reg;
  reg [15:0] mul_reg;
  reg [15:0] shut_us_reg;
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] prev_reg;
  reg pend_reg;
  reg [23:0] dly_cnt_reg;
  reg [15:0] div_cnt_reg;
  reg [15:0] mul_cnt_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [23:0] exp_cnt_reg;
  reg after_exposure_accept_reg;

  wire fr_on = ctrl_reg[`TEC_F_FR_ON];
  wire [2:0] fr_kind = ctrl_reg[`TEC_F_FR_KIND];
  wire [1:0] window = ctrl_reg[`TEC_F_WINDOW];
  wire [1:0] method = ctrl_reg[`TEC_F_METHOD];
  wire [1:0] auto_mode = ctrl_reg[`TEC_F_AUTO];
  wire dedicated = (method == `TEC_DEDICATED_TRIG_SHUTTER);

  // source bit order: frame, open, close, hold
  wire [3:0] src = {hold_src_i, close_src_i, open_src_i, frame_src_i};

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= src;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire fr_ev = fr_on & tec_qualify(fr_kind, sync2_reg[0], prev_reg[0]);
  wire open_ev = dedicated & ctrl_reg[`TEC_F_OPEN_ON] &
    tec_qualify(ctrl_reg[`TEC_F_OPEN_KIND], sync2_reg[1], prev_reg[1]);
  wire close_ev = dedicated & ctrl_reg[`TEC_F_CLOSE_ON] &
    tec_qualify(ctrl_reg[`TEC_F_CLOSE_KIND], sync2_reg[2],
      prev_reg[2]);
  wire hold_on = dedicated & ctrl_reg[`TEC_F_HOLD_ON];
  wire hold_act = hold_on &
    tec_active(ctrl_reg[`TEC_F_HOLD_KIND], sync2_reg[3]);
  wire fr_act = tec_active(fr_kind, sync2_reg[0]);

  wire exposing = state_reg[1];
  wire dly_busy = (dly_cnt_reg != 24'h000000);
  wire chain_busy = dly_busy | (mul_cnt_reg != 16'h0000);

  // acceptance window for new frame triggers
  reg accept_ok;
  always @* begin
    case (window)
      `TEC_WIN_OFF: accept_ok = ~chain_busy & ~exposing & ~after_exposure_accept_reg;
      `TEC_AFTER_EXPOSURE_ACCEPT: accept_ok = ~chain_busy & ~exposing;
      `TEC_DURING_PRIOR_CAPTURE_ACCEPT:
        accept_ok = ~chain_busy & ~exposing & ~after_exposure_accept_reg;
      default: accept_ok = 1'b0;
    endcase
  end

  wire latch_mode = (window == `TEC_DURING_PRIOR_CAPTURE_ACCEPT);
  // latched trigger is replayed once the previous capture is over
  wire acc_start = latch_mode ? ((pend_reg | fr_ev) & accept_ok) :
    (fr_ev & accept_ok);

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
    end else if (dedicated) begin
      pend_reg <= 1'b0;
    end else if (latch_mode & fr_ev & ~accept_ok) begin
      pend_reg <= 1'b1;
    end else if (acc_start | ~latch_mode) begin
      pend_reg <= 1'b0;
    end
  end

  wire [23:0] wait_cyc = tec_us_cyc(wait_us_reg);
  wire dly_pass = (acc_start & (wait_cyc == 24'h000000)) |
    (dly_cnt_reg == 24'h000001);

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_cnt_reg <= 24'h000000;
    end else if (acc_start) begin
      dly_cnt_reg <= wait_cyc;
    end else if (dly_busy) begin
      dly_cnt_reg <= dly_cnt_reg - 24'h000001;
    end
  end

  // a zero divider or multiplier behaves as one
  wire [15:0] div_eff = (div_reg == 16'h0000) ? 16'h0001 : div_reg;
  wire [15:0] mul_eff = (mul_reg == 16'h0000) ? 16'h0001 : mul_reg;
  wire div_fire = dly_pass & (div_cnt_reg + 16'h0001 >= div_eff);

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_reg <= 16'h0000;
    end else if (dly_pass) begin
      if (div_fire) begin
        div_cnt_reg <= 16'h0000;
      end else begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
    end
  end

  // frames issue one at a time; overlapped after_exposure_accept allows a new exposure
  // one idle cycle between starts keeps every frame pulse distinct
  wire can_start = ~dedicated & ~exposing & ~frame_start_o &
    (~after_exposure_accept_reg | (window == `TEC_AFTER_EXPOSURE_ACCEPT));
  wire fs = (mul_cnt_reg != 16'h0000) & can_start;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mul_cnt_reg <= 16'h0000;
    end else if (dedicated) begin
      // no frames issue here, so a stale count must not leak out later
      mul_cnt_reg <= 16'h0000;
    end else if (div_fire) begin
      mul_cnt_reg <= mul_eff;
    end else if (fs) begin
      mul_cnt_reg <= mul_cnt_reg - 16'h0001;
    end
  end

  wire [23:0] shut_cyc = tec_us_cyc(shut_us_reg);
  reg exp_end;
  always @* begin
    state_next = state_reg;
    exp_end = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (dedicated) begin
          if (open_ev | hold_act) begin
            state_next = ST_EXPOSE;
          end
        end else if (fs) begin
          if (method == `TEC_METHOD_FIXED ||
              method == `TEC_PULSE_LENGTH_SHUTTER) begin
            state_next = ST_EXPOSE;
          end
        end
      end
      ST_EXPOSE: begin
        case (method)
          `TEC_METHOD_FIXED:
            exp_end = (exp_cnt_reg <= 24'h000001);
          `TEC_PULSE_LENGTH_SHUTTER: exp_end = ~fr_act;
          `TEC_DEDICATED_TRIG_SHUTTER:
            exp_end = close_ev | (hold_on & ~hold_act);
          default: exp_end = 1'b1;
        endcase
        if (exp_end) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      exp_cnt_reg <= 24'h000000;
      after_exposure_accept_reg <= 1'b0;
      frame_start_o <= 1'b0;
      shutter_open_o <= 1'b1;
    end else begin
      state_reg <= state_next;
      frame_start_o <= fs;
      if (state_reg == ST_IDLE && state_next == ST_EXPOSE) begin
        exp_cnt_reg <= shut_cyc;
      end else if (exp_cnt_reg != 24'h000000) begin
        exp_cnt_reg <= exp_cnt_reg - 24'h000001;
      end
      // a frame entering after_exposure_accept in the same cycle as an old one leaves it wins
      if (exp_end | (fs & (method == `TEC_METHOD_OFF))) begin
        after_exposure_accept_reg <= 1'b1;
      end else if (after_exposure_accept_done_i) begin
        after_exposure_accept_reg <= 1'b0;
      end
      if (method == `TEC_METHOD_OFF) begin
        shutter_open_o <= 1'b1;
      end else begin
        shutter_open_o <= (state_next == ST_EXPOSE);
      end
    end
  end

  assign capture_busy_o = exposing | after_exposure_accept_reg;

  // auto adjustment is judged at the close of each fixed exposure
  wire auto_step = exp_end & (method == `TEC_METHOD_FIXED) &
    (auto_mode != `TEC_AUTO_OFF);
  wire go_down = scene_bright_i & (shut_us_reg > `TEC_AUTO_STEP_US);
  wire go_up = scene_dark_i &
    (shut_us_reg < `TEC_SHUT_MAX_US - `TEC_AUTO_STEP_US);

  wire addr_wait = (reg_addr_i == `TEC_ADDR_WAIT) |
    (reg_addr_i == `TEC_ADDR_LEG_WAIT_US) |
    (reg_addr_i == `TEC_ADDR_LEG_WAIT_TICKS);
  wire addr_shut = (reg_addr_i == `TEC_ADDR_SHUT) |
    (reg_addr_i == `TEC_ADDR_LEG_SHUT_US) |
    (reg_addr_i == `TEC_ADDR_LEG_SHUT_TICKS);

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `TEC_CTRL_RST;
      wait_us_reg <= `TEC_WAIT_RST;
      div_reg <= `TEC_DIV_RST;
      mul_reg <= `TEC_MUL_RST;
      shut_us_reg <= `TEC_SHUT_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == `TEC_ADDR_CTRL) begin
        ctrl_reg <= reg_wdata_i[`TEC_CTRL_W-1:0];
      end else if (auto_step && auto_mode == `TEC_AUTO_ONCE &&
                   !go_down && !go_up) begin
        ctrl_reg[`TEC_F_AUTO] <= `TEC_AUTO_OFF;
      end
      // raw tick unit is one microsecond, so all forms share one store
      if (reg_wr_i && addr_wait) begin
        wait_us_reg <= reg_wdata_i[15:0];
      end
      if (reg_wr_i && reg_addr_i == `TEC_ADDR_DIV) begin
        div_reg <= reg_wdata_i[15:0];
      end
      if (reg_wr_i && reg_addr_i == `TEC_ADDR_MUL) begin
        mul_reg <= reg_wdata_i[15:0];
      end
      if (reg_wr_i && addr_shut) begin
        shut_us_reg <= reg_wdata_i[15:0];
      end else if (auto_step && go_down) begin
        shut_us_reg <= shut_us_reg - `TEC_AUTO_STEP_US;
      end else if (auto_step && go_up) begin
        shut_us_reg <= shut_us_reg + `TEC_AUTO_STEP_US;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (addr_wait) begin
      reg_rdata_o <= {16'h0000, wait_us_reg};
    end else if (addr_shut) begin
      reg_rdata_o <= {16'h0000, shut_us_reg};
    end else begin
      case (reg_addr_i)
        `TEC_ADDR_CTRL: reg_rdata_o <= {10'h000, ctrl_reg};
        `TEC_ADDR_DIV: reg_rdata_o <= {16'h0000, div_reg};
        `TEC_ADDR_MUL: reg_rdata_o <= {16'h0000, mul_reg};
        `TEC_ADDR_STATUS:
          reg_rdata_o <= {mul_cnt_reg, 11'h000, dly_busy, pend_reg,
            after_exposure_accept_reg, exposing, shutter_open_o};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end
  end

endmodule // tec_trigger_exposure

/* hdl/tec_trigger_exposure_map.vh */
// Notes on behaviour
// - rise kind fires on low-to-high only
// - fall kind fires on high-to-low only
// - either kind fires on every transition
// - high kind valid while source high
// - low kind valid while source low
// - no overlap: ignore triggers during capture
// - after-exposure window: accept once exposure ends
// - prior-capture window: latch trigger, use next
// - programmable microsecond wait before trigger acts
// - wait settings in both forms stay equal
// - divider passes one of every N pulses
// - multiplier emits M frame starts per pulse
// - method off: shutter stays permanently open
// - fixed method: open at start, timed close
// - pulse-length method follows trigger active level
// - dedicated method: open/close/hold triggers rule
// - shutter triggers ignored unless method dedicated
// - hold duration in us for fixed method
// - auto adjust acts only in fixed method
// - once mode converges then returns to off
// - continuous mode adjusts without stopping
// - shutter time settings in both forms agree
// - per-trigger on/off; off triggers fully ignored
`ifndef TEC_TRIGGER_EXPOSURE_MAP_VH
`define TEC_TRIGGER_EXPOSURE_MAP_VH

`define TEC_ADDR_CTRL 8'h00
`define TEC_ADDR_WAIT 8'h04
`define TEC_ADDR_LEG_WAIT_US 8'h08
`define TEC_ADDR_LEG_WAIT_TICKS 8'h0c
`define TEC_ADDR_DIV 8'h10
`define TEC_ADDR_MUL 8'h14
`define TEC_ADDR_SHUT 8'h18
`define TEC_ADDR_LEG_SHUT_US 8'h1c
`define TEC_ADDR_LEG_SHUT_TICKS 8'h20
`define TEC_ADDR_STATUS 8'h24

// control register fields
`define TEC_F_FR_ON 0
`define TEC_F_FR_KIND 3:1
`define TEC_F_WINDOW 5:4
`define TEC_F_OPEN_ON 6
`define TEC_F_CLOSE_ON 7
`define TEC_F_HOLD_ON 8
`define TEC_F_HOLD_KIND 11:9
`define TEC_F_OPEN_KIND 14:12
`define TEC_F_CLOSE_KIND 17:15
`define TEC_F_METHOD 19:18
`define TEC_F_AUTO 21:20
`define TEC_CTRL_W 22

`define TEC_CTRL_RST 22'h000000
`define TEC_WAIT_RST 16'h0000
`define TEC_DIV_RST 16'h0001
`define TEC_MUL_RST 16'h0001
`define TEC_SHUT_RST 16'h03e8

// trig_qualify_kind codes
`define TEC_RISE_TRANSITION 3'h0
`define TEC_FALL_TRANSITION 3'h1
`define TEC_EITHER_TRANSITION 3'h2
`define TEC_WHILE_HIGH 3'h3
`define TEC_WHILE_LOW 3'h4
// trig_accept_window codes
`define TEC_WIN_OFF 2'h0
`define TEC_AFTER_EXPOSURE_ACCEPT 2'h1
`define TEC_DURING_PRIOR_CAPTURE_ACCEPT 2'h2
// shutter_method codes
`define TEC_METHOD_OFF 2'h0
`define TEC_METHOD_FIXED 2'h1
`define TEC_PULSE_LENGTH_SHUTTER 2'h2
`define TEC_DEDICATED_TRIG_SHUTTER 2'h3
// auto_shutter_adjust codes
`define TEC_AUTO_OFF 2'h0
`define TEC_AUTO_ONCE 2'h1
`define TEC_AUTO_CONT 2'h2

// timing
`define TEC_CLK_PERIOD_NS 10
`define TEC_NS_PER_US 1000
`define TEC_CYC_PER_US (`TEC_NS_PER_US / `TEC_CLK_PERIOD_NS)
`define TEC_AUTO_STEP_US 16'h0010
`define TEC_SHUT_MAX_US 16'hffff

`endif
